//--- logic/kpi_pkg.sv
// Purpose: Constants shared by the keypad pin interrupt unit.
// Assumes: APB byte addresses are four times the register index.
// Notes:   Register indices are kept as printed and scaled once here.

package kpi_pkg;

  // ---------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------
  localparam logic [11:0] IDX_POLARITY = 12'h09C;
  localparam logic [11:0] IDX_ENABLE   = 12'h09D;
  localparam logic [11:0] IDX_FLAGS    = 12'h09E;
  localparam logic [11:0] IDX_MODE     = 12'h09F;
  localparam logic [11:0] IDX_EVT_STAT = 12'h0A0;
  localparam logic [11:0] IDX_EVT_MASK = 12'h0A1;

  localparam logic [11:0] ADDR_POLARITY = {IDX_POLARITY[9:0], 2'b00};
  localparam logic [11:0] ADDR_ENABLE   = {IDX_ENABLE[9:0], 2'b00};
  localparam logic [11:0] ADDR_FLAGS    = {IDX_FLAGS[9:0], 2'b00};
  localparam logic [11:0] ADDR_MODE     = {IDX_MODE[9:0], 2'b00};
  localparam logic [11:0] ADDR_EVT_STAT = {IDX_EVT_STAT[9:0], 2'b00};
  localparam logic [11:0] ADDR_EVT_MASK = {IDX_EVT_MASK[9:0], 2'b00};

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int          PIN_COUNT = 8;
  localparam int          ADDR_W    = 12;
  localparam logic [7:0]  REG_RESET = 8'h00;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;

  // Field meaning of a mode bit and a polarity bit.
  localparam logic MODE_LEVEL = 1'b0;
  localparam logic MODE_EDGE  = 1'b1;
  localparam logic POL_LOW    = 1'b0;
  localparam logic POL_HIGH   = 1'b1;

endpackage

//--- logic/kpi_keypad_pin_interrupts.sv
// Purpose: Eight-pin keypad and general-purpose interrupt unit, APB slave.
// Assumes: Pin inputs are synchronous to core_clk; rst is synchronous.
// Notes:   Detection is never gated by idle or power-down, so a pending
//          wake condition is seen with the core otherwise asleep.
//
// Added by the designer: register access over APB.

`timescale 1ns/1ps

// Notes on behaviour
// RULE1: Eight pins are separate sources sharing one interrupt request.
// RULE2: A pin raises its flag only while its enable bit is one.
// RULE3: Mode bit zero selects level detection, one selects edge detection.
// RULE4: Polarity zero means low or falling, one means high or rising.
// RULE5: All eight pins are sampled on every clock.
// RULE6: Level detection needs the selected level in two consecutive samples.
// RULE7: Edge detection fires when a sample has the selected level and the last one did not.
// RULE8: A detected condition sets the pin flag until software clears it.
// RULE9: Reading the flag register clears nothing.
// RULE10: Software can clear one flag or all flags, others stay pending.
// RULE11: Writing one to a flag sets it as though hardware had.
// RULE12: Any enabled condition wakes the device from idle or power-down.
// RULE13: Pin detection stays running during power-down.
// RULE14: Reset clears all four keypad registers to zero.
// RULE15: Shared request is high while any flag is set.
module kpi_keypad_pin_interrupts #(
  parameter int NUM_PINS = kpi_pkg::PIN_COUNT
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [kpi_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [NUM_PINS-1:0]         keyboard_port_pin,
  input  wire logic                        idle_i,
  input  wire logic                        power_down_i,
  output logic                             key_irq_o,
  output logic                             evt_irq_o,
  output logic                             wake_o
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [NUM_PINS-1:0] key_polarity_select_q;
  logic [NUM_PINS-1:0] key_irq_enable_q;
  logic [NUM_PINS-1:0] key_irq_flags_q;
  logic [NUM_PINS-1:0] key_trigger_mode_q;
  logic [NUM_PINS-1:0] evt_status_q;
  logic [NUM_PINS-1:0] evt_mask_q;
  logic [NUM_PINS-1:0] sample_q;
  logic [NUM_PINS-1:0] prev_q;
  logic [31:0]         prdata_q;
  logic                pslverr_q;
  logic                wake_q;

  logic [NUM_PINS-1:0] key_irq_flags_d;
  logic [NUM_PINS-1:0] evt_status_d;
  logic                wake_d;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire logic setup_w  = psel & ~penable;
  wire logic access_w = psel & penable;
  wire logic wr_w     = access_w & pwrite & pstrb[0];

  wire logic hit_pol_w  = (paddr == kpi_pkg::ADDR_POLARITY);
  wire logic hit_en_w   = (paddr == kpi_pkg::ADDR_ENABLE);
  wire logic hit_flag_w = (paddr == kpi_pkg::ADDR_FLAGS);
  wire logic hit_mode_w = (paddr == kpi_pkg::ADDR_MODE);
  wire logic hit_stat_w = (paddr == kpi_pkg::ADDR_EVT_STAT);
  wire logic hit_mask_w = (paddr == kpi_pkg::ADDR_EVT_MASK);
  wire logic mapped_w   = hit_pol_w | hit_en_w | hit_flag_w |
                          hit_mode_w | hit_stat_w | hit_mask_w;

  wire logic wr_pol_w  = wr_w & hit_pol_w;
  wire logic wr_en_w   = wr_w & hit_en_w;
  wire logic wr_flag_w = wr_w & hit_flag_w;
  wire logic wr_mode_w = wr_w & hit_mode_w;
  wire logic wr_stat_w = wr_w & hit_stat_w;
  wire logic wr_mask_w = wr_w & hit_mask_w;

  wire logic [NUM_PINS-1:0] wdata_w = pwdata[NUM_PINS-1:0];

  // Read data is captured in the setup cycle so that the access phase
  // completes at once; the flags may move by one cycle meanwhile.
  logic [NUM_PINS-1:0] rd_sel_w;
  always_comb begin
    if (hit_pol_w) begin
      rd_sel_w = key_polarity_select_q;
    end else if (hit_en_w) begin
      rd_sel_w = key_irq_enable_q;
    end else if (hit_flag_w) begin
      rd_sel_w = key_irq_flags_q; // RULE9
    end else if (hit_mode_w) begin
      rd_sel_w = key_trigger_mode_q;
    end else if (hit_stat_w) begin
      rd_sel_w = evt_status_q;
    end else if (hit_mask_w) begin
      rd_sel_w = evt_mask_q;
    end else begin
      rd_sel_w = '0;
    end
  end

  wire logic [31:0] rd_word_w = {{(32-NUM_PINS){1'b0}}, rd_sel_w};

  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata_q  <= kpi_pkg::RD_ZERO;
      pslverr_q <= 1'b0;
    end else if (setup_w) begin
      prdata_q  <= rd_word_w;
      pslverr_q <= ~mapped_w;
    end
  end

  // ---------------------------------------------------------------
  // Pin sampling and detection
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sample_q <= '0;
      prev_q   <= '0;
    end else begin
      sample_q <= keyboard_port_pin; // RULE5 RULE13
      prev_q   <= sample_q;
    end
  end

  // A bit is one where the sample equals the selected polarity.
  wire logic [NUM_PINS-1:0] now_match_w  =
    ~(sample_q ^ key_polarity_select_q); // RULE4
  wire logic [NUM_PINS-1:0] prev_match_w =
    ~(prev_q ^ key_polarity_select_q);

  wire logic [NUM_PINS-1:0] level_cond_w =
    now_match_w & prev_match_w; // RULE6
  wire logic [NUM_PINS-1:0] edge_cond_w  =
    now_match_w & ~prev_match_w; // RULE7

  wire logic [NUM_PINS-1:0] level_hit_w =
    level_cond_w & ~key_trigger_mode_q & key_irq_enable_q; // RULE3 RULE2
  wire logic [NUM_PINS-1:0] edge_hit_w  =
    edge_cond_w & key_trigger_mode_q & key_irq_enable_q; // RULE3 RULE2
  wire logic [NUM_PINS-1:0] hit_w = level_hit_w | edge_hit_w;

  // ---------------------------------------------------------------
  // Flags, event status and wake
  // ---------------------------------------------------------------
  // A write stores the value, so ones set and zeros clear; a detection in
  // the same cycle still wins over a clearing zero.
  always_comb begin
    key_irq_flags_d = key_irq_flags_q;
    if (wr_flag_w) begin
      key_irq_flags_d = wdata_w; // RULE10 RULE11
    end
    key_irq_flags_d = key_irq_flags_d | hit_w; // RULE8
  end

  always_comb begin
    evt_status_d = evt_status_q;
    if (wr_stat_w) begin
      evt_status_d = evt_status_q & ~wdata_w;
    end
    evt_status_d = evt_status_d | hit_w;
  end

  wire logic asleep_w = idle_i | power_down_i;

  // Wake holds until the core leaves idle or power-down.
  always_comb begin
    wake_d = wake_q & asleep_w;
    if (asleep_w && (|hit_w)) begin
      wake_d = 1'b1; // RULE12
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      key_polarity_select_q <= kpi_pkg::REG_RESET[NUM_PINS-1:0]; // RULE14
      key_irq_enable_q      <= kpi_pkg::REG_RESET[NUM_PINS-1:0];
      key_irq_flags_q       <= kpi_pkg::REG_RESET[NUM_PINS-1:0];
      key_trigger_mode_q    <= kpi_pkg::REG_RESET[NUM_PINS-1:0];
    end else begin
      if (wr_pol_w) begin
        key_polarity_select_q <= wdata_w;
      end
      if (wr_en_w) begin
        key_irq_enable_q <= wdata_w;
      end
      if (wr_mode_w) begin
        key_trigger_mode_q <= wdata_w;
      end
      key_irq_flags_q <= key_irq_flags_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      evt_status_q <= '0;
      evt_mask_q   <= '0;
      wake_q       <= 1'b0;
    end else begin
      evt_status_q <= evt_status_d;
      wake_q       <= wake_d;
      if (wr_mask_w) begin
        evt_mask_q <= wdata_w;
      end
    end
  end

  assign key_irq_o = |key_irq_flags_q; // RULE1 RULE15
  assign evt_irq_o = |(evt_status_q & evt_mask_q);
  assign wake_o    = wake_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_REQ_FOLLOWS_FLAGS: assert property (  // RULE15
    @(posedge core_clk) disable iff (rst)
    (|hit_w) |=> key_irq_o)
    else $error("shared request did not follow a detection");

  AST_REQ_DROPS: assert property (  // RULE15
    @(posedge core_clk) disable iff (rst)
    (wr_flag_w && pwdata[NUM_PINS-1:0] == '0 && hit_w == '0)
    |=> !key_irq_o)
    else $error("shared request stayed high with all flags clear");

  AST_DISABLED_PIN_SILENT: assert property (  // RULE2
    @(posedge core_clk) disable iff (rst)
    !wr_flag_w |=> ((key_irq_flags_q & ~$past(key_irq_flags_q))
                    & ~$past(key_irq_enable_q)) == '0)
    else $error("a disabled pin raised its flag");

  AST_LEVEL_TWO_SAMPLES: assert property (  // RULE6
    @(posedge core_clk) disable iff (rst)
    (|level_hit_w) |=> (key_irq_flags_q & $past(level_hit_w))
                       == $past(level_hit_w))
    else $error("level held two samples did not set the flags");

  AST_LEVEL_ONE_SAMPLE_QUIET: assert property (  // RULE6
    @(posedge core_clk) disable iff (rst)
    !wr_flag_w |=> (key_irq_flags_q & ~$past(key_irq_flags_q)
                    & $past(~key_trigger_mode_q & ~prev_match_w)) == '0)
    else $error("level seen in one sample set a flag");

  AST_EDGE_NEEDS_CHANGE: assert property (  // RULE7
    @(posedge core_clk) disable iff (rst)
    !wr_flag_w |=> (key_irq_flags_q & ~$past(key_irq_flags_q)
                    & $past(key_trigger_mode_q & ~(sample_q ^ prev_q)))
                   == '0)
    else $error("edge flag set without a change of sample");

  AST_WRONG_POLARITY_QUIET: assert property (  // RULE4
    @(posedge core_clk) disable iff (rst)
    !wr_flag_w |=> (key_irq_flags_q & ~$past(key_irq_flags_q)
                    & $past(sample_q ^ key_polarity_select_q)) == '0)
    else $error("flag set by the unselected polarity");

  AST_EDGE_SETS_FLAG: assert property (  // RULE7
    @(posedge core_clk) disable iff (rst)
    (|edge_hit_w) |=> (key_irq_flags_q & $past(edge_hit_w))
                      == $past(edge_hit_w))
    else $error("detected edge did not set its flag");

  AST_FLAG_STICKY: assert property (  // RULE8
    @(posedge core_clk) disable iff (rst)
    !wr_flag_w |=> (key_irq_flags_q & $past(key_irq_flags_q))
                   == $past(key_irq_flags_q))
    else $error("a flag fell without a software write");

  AST_READ_KEEPS_FLAGS: assert property (  // RULE9
    @(posedge core_clk) disable iff (rst)
    (access_w && !pwrite && hit_flag_w)
    |=> (key_irq_flags_q & $past(key_irq_flags_q))
        == $past(key_irq_flags_q))
    else $error("reading the flags cleared one");

  AST_WRITE_CLEARS: assert property (  // RULE10
    @(posedge core_clk) disable iff (rst)
    (wr_flag_w && hit_w == '0)
    |=> key_irq_flags_q == $past(pwdata[NUM_PINS-1:0]))
    else $error("flag write did not leave the written pattern");

  AST_WRITE_ONE_SETS: assert property (  // RULE11
    @(posedge core_clk) disable iff (rst)
    wr_flag_w |=> (key_irq_flags_q & $past(pwdata[NUM_PINS-1:0]))
                  == $past(pwdata[NUM_PINS-1:0]))
    else $error("writing one did not set the flag");

  AST_RESET_ZERO: assert property (  // RULE14
    @(posedge core_clk)
    rst |=> (key_polarity_select_q == '0 && key_irq_enable_q == '0
             && key_irq_flags_q == '0 && key_trigger_mode_q == '0))
    else $error("keypad registers not zero after reset");

  AST_WAKE_ON_HIT: assert property (  // RULE12
    @(posedge core_clk) disable iff (rst)
    (power_down_i && (|hit_w)) ##1 power_down_i |-> wake_o)
    else $error("enabled condition in power-down did not wake");

  AST_IDLE_WAKE: assert property (  // RULE12
    @(posedge core_clk) disable iff (rst)
    (idle_i && (|hit_w)) |=> wake_o)
    else $error("enabled condition in idle did not wake");

  AST_WAKE_HOLDS: assert property (  // RULE12
    @(posedge core_clk) disable iff (rst)
    (wake_o && asleep_w) |=> wake_o)
    else $error("wake fell while the core still slept");

  AST_WAKE_FALLS: assert property (  // RULE12
    @(posedge core_clk) disable iff (rst)
    !asleep_w |=> !wake_o)
    else $error("wake stayed high with the core awake");

  AST_EVT_STICKY: assert property (  // RULE8
    @(posedge core_clk) disable iff (rst)
    !wr_stat_w |=> (evt_status_q & $past(evt_status_q))
                   == $past(evt_status_q))
    else $error("an event status bit fell without a write");

  // ---------------------------------------------------------------
  // Bus assertions
  // ---------------------------------------------------------------
  // The slave never stalls, so a master never waits; unmapped addresses still get an error.
  AST_PREADY_HIGH: assert property (
    @(posedge core_clk) disable iff (rst)
    pready)
    else $error("ready fell");

  AST_UNMAPPED_ERR: assert property (
    @(posedge core_clk) disable iff (rst)
    (setup_w && !mapped_w) |=> pslverr)
    else $error("unmapped access gave no error");

  AST_MAPPED_OK: assert property (
    @(posedge core_clk) disable iff (rst)
    (setup_w && mapped_w) |=> !pslverr)
    else $error("mapped access gave an error");

  AST_UPPER_ZERO: assert property (
    @(posedge core_clk) disable iff (rst)
    prdata[31:NUM_PINS] == '0)
    else $error("read data upper bits not zero");

  AST_RD_FLAGS: assert property (  // RULE9
    @(posedge core_clk) disable iff (rst)
    (setup_w && hit_flag_w)
    |=> prdata[NUM_PINS-1:0] == $past(key_irq_flags_q))
    else $error("flag read returned the wrong pattern");

  AST_STRB_OFF_IGNORED: assert property (  // RULE2
    @(posedge core_clk) disable iff (rst)
    (access_w && pwrite && !pstrb[0] && hit_en_w)
    |=> $stable(key_irq_enable_q))
    else $error("write without low strobe changed the enables");

endmodule // kpi_keypad_pin_interrupts

//--- test/kpi_pin_source.sv
// Purpose: Keyboard model driving the eight port pins.
// Assumes: Pins change just after a rising edge of core_clk.
// Notes:   Unplugged pins read high, as port pull-ups would make them.

`timescale 1ns/1ps

module kpi_pin_source (
  input  wire logic       core_clk,
  input  wire logic       plugged,
  input  wire logic [7:0] target,
  output logic      [7:0] pins
);
  initial pins = 8'hFF;
  // Whole-cycle changes only, so each level is seen by one sample or more.
  always @(posedge core_clk) begin
    pins <= plugged ? target : 8'hFF;
  end
endmodule // kpi_pin_source

//--- test/kpi_keypad_pin_interrupts_tb.sv
// Purpose: Self-checking bench comparing the unit with a reference model.
// Assumes: Zero-wait APB slave; flags are readable one cycle stale.
// Notes:   Random pins and settings from a fixed seed.

`timescale 1ns/1ps

module kpi_keypad_pin_interrupts_tb;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, exp_rd;
  logic [3:0]  pstrb;
  logic [7:0]  pins, target, h, e, l;
  logic        idle_i, power_down_i, key_irq_o, evt_irq_o, wake_o;
  logic        plugged, exp_err, wr, wake_m, live;
  logic [7:0]  pol_m, en_m, flg_m, mod_m, st_m, mk_m, smp_m, prv_m;
  int          fails, tests_run, cyc;
  localparam int LIMIT = 20000;

  kpi_keypad_pin_interrupts i_dut (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .keyboard_port_pin(pins), .idle_i(idle_i),
    .power_down_i(power_down_i), .key_irq_o(key_irq_o),
    .evt_irq_o(evt_irq_o), .wake_o(wake_o));
  kpi_pin_source i_src (.core_clk(core_clk), .plugged(plugged),
    .target(target), .pins(pins));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    e = (pol_m & smp_m & ~prv_m) | (~pol_m & ~smp_m & prv_m);
    l = (pol_m & smp_m & prv_m) | (~pol_m & ~smp_m & ~prv_m);
    h = en_m & ((mod_m & e) | (~mod_m & l));
    wr = psel && penable && pwrite && pstrb[0];
    if (rst) begin
      {pol_m, en_m, flg_m, mod_m, st_m, mk_m, smp_m, prv_m} <= '0;
      wake_m <= 1'b0;
    end else begin
      if (psel && !penable) begin
        case (paddr)
          kpi_pkg::ADDR_POLARITY: exp_rd <= {24'h0, pol_m};
          kpi_pkg::ADDR_ENABLE:   exp_rd <= {24'h0, en_m};
          kpi_pkg::ADDR_FLAGS:    exp_rd <= {24'h0, flg_m};
          kpi_pkg::ADDR_MODE:     exp_rd <= {24'h0, mod_m};
          kpi_pkg::ADDR_EVT_STAT: exp_rd <= {24'h0, st_m};
          kpi_pkg::ADDR_EVT_MASK: exp_rd <= {24'h0, mk_m};
          default:                exp_rd <= 32'h0000_0000;
        endcase
        exp_err <= paddr > kpi_pkg::ADDR_EVT_MASK || paddr < 12'h270;
      end
      flg_m <= (wr && paddr == kpi_pkg::ADDR_FLAGS) ? pwdata[7:0] | h
                                                   : flg_m | h;
      st_m <= (wr && paddr == kpi_pkg::ADDR_EVT_STAT)
              ? (st_m & ~pwdata[7:0]) | h : st_m | h;
      if (wr && paddr == kpi_pkg::ADDR_POLARITY) pol_m <= pwdata[7:0];
      if (wr && paddr == kpi_pkg::ADDR_ENABLE) en_m <= pwdata[7:0];
      if (wr && paddr == kpi_pkg::ADDR_MODE) mod_m <= pwdata[7:0];
      if (wr && paddr == kpi_pkg::ADDR_EVT_MASK) mk_m <= pwdata[7:0];
      prv_m <= smp_m;
      smp_m <= pins;
      wake_m <= (idle_i || power_down_i) && (wake_m || h != 8'h00);
    end
  end

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(negedge core_clk) begin
    if (live) begin
      check({31'h0, key_irq_o}, {31'h0, flg_m != 8'h00});
      check({31'h0, evt_irq_o}, {31'h0, (st_m & mk_m) != 8'h00});
      check({31'h0, wake_o}, {31'h0, wake_m});
    end
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    if (!w) check(prdata, exp_rd);
    check({31'h0, pslverr}, {31'h0, exp_err});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, target} = '0;
    {idle_i, power_down_i, plugged, live, fails, tests_run, cyc} = '0;
    rst = 1'b1;
    void'($urandom(31));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    live = 1'b1;
    for (int i = 0; i < 7; i++) apb(1'b0, 12'h270 + 12'(4 * i), 0, 0);
    plugged <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      apb(1'b1, kpi_pkg::ADDR_MODE, $urandom, 4'h1);
      apb(1'b1, kpi_pkg::ADDR_POLARITY, $urandom, 4'h1);
      apb(1'b1, kpi_pkg::ADDR_ENABLE, $urandom, 4'($urandom));
      apb(1'b1, kpi_pkg::ADDR_EVT_MASK, $urandom, 4'h1);
      idle_i <= ($urandom % 4) == 0;
      power_down_i <= ($urandom % 4) == 0;
      for (int k = 0; k < 12; k++) begin
        target <= 8'($urandom);
        @(posedge core_clk);
      end
      for (int i = 0; i < 7; i++) apb(1'b0, 12'h270 + 12'(4 * i), 0, 0);
      apb(1'b0, kpi_pkg::ADDR_FLAGS, 0, 0);
      apb(1'b1, kpi_pkg::ADDR_FLAGS, $urandom, 4'($urandom));
      apb(1'b1, kpi_pkg::ADDR_EVT_STAT, $urandom, 4'h1);
      apb(1'b1, 12'h288, $urandom, 4'hF);
      apb(1'b0, kpi_pkg::ADDR_FLAGS, 0, 0);
    end
    report_and_stop();
  end
endmodule // kpi_keypad_pin_interrupts_tb
